// ==== mpb_pkg.sv ====
package mpb_pkg;

	// ----------------------------------------------------------------
	// Frame geometry
	// ----------------------------------------------------------------
	localparam int MPB_DATA_W = 8;
	localparam logic [3:0] MPB_ROWS = 4'h9;
	localparam logic [3:0] MPB_PTR_ROW = 4'h3;
	localparam logic [3:0] MPB_J0_ROW = 4'h0;
	localparam logic [3:0] MPB_K_ROW = 4'h4;
	// STM-1 columns: 270 total, 9 of overhead
	localparam logic [8:0] MPB_COLS_STM1 = 9'h10e;
	localparam logic [8:0] MPB_SOH_STM1 = 9'h009;
	localparam logic [8:0] MPB_J0_COL_STM1 = 9'h006;
	localparam logic [8:0] MPB_K1_COL_STM1 = 9'h003;
	localparam logic [8:0] MPB_K2_COL_STM1 = 9'h006;
	// STM-0 columns: 90 total, 3 of overhead
	localparam logic [8:0] MPB_COLS_STM0 = 9'h05a;
	localparam logic [8:0] MPB_SOH_STM0 = 9'h003;
	localparam logic [8:0] MPB_J0_COL_STM0 = 9'h002;
	localparam logic [8:0] MPB_K1_COL_STM0 = 9'h001;
	localparam logic [8:0] MPB_K2_COL_STM0 = 9'h002;

	// ----------------------------------------------------------------
	// Rates and clocking
	// ----------------------------------------------------------------
	localparam int MPB_CLK_KHZ = 20000;
	localparam int MPB_STM0_KHZ = 6480;
	localparam int MPB_STM1_KHZ = 19440;
	localparam int MPB_HALF_DIV_DEF = 4;
	localparam logic [7:0] MPB_DIV_RST = 8'h00;
	localparam logic [7:0] MPB_BYTE_RST = 8'h00;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] row;
		logic [8:0] col;
	} mpb_pos_t;

	localparam mpb_pos_t MPB_POS_RST = '{row: 4'h0, col: 9'h000};

	typedef struct packed {
		logic [7:0] data;
		logic frame;
	} mpb_tx_pin_t;

	typedef struct packed {
		logic [7:0] data;
		logic frame;
		logic payload_en;
		logic signal_fail;
		logic signal_degrade;
	} mpb_rx_pin_t;

	typedef struct packed {
		logic [7:0] data;
		logic frame;
		logic payload_en;
	} mpb_rx_src_t;

	typedef enum logic [1:0] {
		MPB_HUNT = 2'b00,
		MPB_ALIGN = 2'b01,
		MPB_LOCK = 2'b11
	} mpb_align_t;

endpackage : mpb_pkg

// ==== mpb_sync.sv ====
module mpb_sync
	import mpb_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	// ----------------------------------------------------------------
	// Three-stage sampler
	// ----------------------------------------------------------------
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] agree;

	if (W < 1) begin : g_chk
		$error("mpb_sync needs W of at least one");
	end

	// A bit counts only once stages two and three agree
	assign agree = ~(s2_q ^ s3_q);

	// Stage one feeds stage two only, to keep metastability contained
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			q_o <= '0;
		end else if (ce_i) begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q_o <= (agree & s3_q) | (~agree & q_o);
		end
	end

endmodule : mpb_sync

// ==== mpb_port.sv ====
// Operation
// - Tx slave keeps only AU bytes valid
// - Tx slave samples on link clock fall
// - Tx J0 pulse aligns transmit frame
// - Tx slave payload enable stays undriven
// - Tx clock out feeds overhead bus
// - Rx master accepts framed data bytes
// - Rx master clock out feeds overhead
// - Rx J0 pulse recovers switching bytes
// - Payload enable marks container bytes
// - Rx master accepts fail and degrade
// - Rx slave drives framed data out
// - Rx slave ignores receive clock input
// - Rx slave clock out, data on rise
// - Rx clock out feeds overhead bus
// - Rx slave pulses frame at J0
// - Rx slave payload enable marks container
// - Rx slave drives fail and degrade
module mpb_port
	import mpb_pkg::*;
#(
	parameter int HALF_DIV = MPB_HALF_DIV_DEF
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic rate_select_i,
	input wire logic tx_slave_i,
	input wire logic rx_slave_i,
	input wire logic tx_prot_clk_in_i,
	input wire mpb_tx_pin_t tx_prot_i,
	output logic tx_prot_clk_out_o,
	output logic tx_prot_payload_en_o,
	output logic tx_prot_payload_en_oe_o,
	output logic [7:0] tx_byte_o,
	output logic tx_byte_valid_o,
	output logic tx_byte_stb_o,
	output logic tx_frame_align_o,
	output logic tx_locked_o,
	input wire logic rx_prot_clk_in_i,
	input wire mpb_rx_pin_t rx_prot_i,
	output mpb_rx_pin_t rx_prot_o,
	output logic rx_prot_oe_o,
	output logic rx_prot_clk_out_o,
	input wire mpb_rx_src_t rx_src_i,
	input wire logic rx_defect_i,
	input wire logic rx_degrade_i,
	output logic rx_src_take_o,
	output logic [7:0] rx_vc_byte_o,
	output logic rx_vc_valid_o,
	output logic rx_frame_o,
	output logic [7:0] rx_k1_o,
	output logic [7:0] rx_k2_o,
	output logic rx_aps_valid_o,
	output logic rx_sf_o,
	output logic rx_sd_o
);

	// ----------------------------------------------------------------
	// Frame position helpers
	// ----------------------------------------------------------------
	function automatic logic [8:0] mpb_cols(input logic stm1);
		return stm1 ? MPB_COLS_STM1 : MPB_COLS_STM0;
	endfunction : mpb_cols

	function automatic mpb_pos_t mpb_advance(input mpb_pos_t p,
		input logic stm1);
		mpb_pos_t n;
		n = p;
		if (p.col >= mpb_cols(stm1) - 9'h001) begin
			n.col = 9'h000;
			n.row = (p.row >= MPB_ROWS - 4'h1) ? 4'h0 : p.row + 4'h1;
		end else begin
			n.col = p.col + 9'h001;
		end
		return n;
	endfunction : mpb_advance

	function automatic logic mpb_in_soh(input mpb_pos_t p,
		input logic stm1);
		return p.col < (stm1 ? MPB_SOH_STM1 : MPB_SOH_STM0);
	endfunction : mpb_in_soh

	function automatic mpb_pos_t mpb_at(input logic [3:0] r,
		input logic [8:0] c1, input logic [8:0] c0, input logic stm1);
		mpb_pos_t n;
		n.row = r;
		n.col = stm1 ? c1 : c0;
		return n;
	endfunction : mpb_at

	if (HALF_DIV < 1 || HALF_DIV > 255) begin : g_chk
		$error("mpb_port HALF_DIV must lie in 1..255");
	end

	// ----------------------------------------------------------------
	// Shared decode
	// ----------------------------------------------------------------
	wire mpb_pos_t j0_pos = mpb_at(MPB_J0_ROW, MPB_J0_COL_STM1,
		MPB_J0_COL_STM0, rate_select_i);
	wire mpb_pos_t k1_pos = mpb_at(MPB_K_ROW, MPB_K1_COL_STM1,
		MPB_K1_COL_STM0, rate_select_i);
	wire mpb_pos_t k2_pos = mpb_at(MPB_K_ROW, MPB_K2_COL_STM1,
		MPB_K2_COL_STM0, rate_select_i);

	// ----------------------------------------------------------------
	// Transmit slave side
	// ----------------------------------------------------------------
	logic [9:0] tx_sync;
	logic tx_clk_q;
	mpb_pos_t tx_pos_q;
	mpb_align_t tx_state_q;
	mpb_align_t tx_state_d;

	mpb_sync #(.W(10)) u_tx_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.d_i({tx_prot_clk_in_i, tx_prot_i}),
		.q_o(tx_sync)
	);

	wire tx_clk_s = tx_sync[9];
	wire mpb_tx_pin_t tx_pin = mpb_tx_pin_t'(tx_sync[8:0]);
	wire tx_take = tx_slave_i & tx_clk_q & ~tx_clk_s;
	wire mpb_pos_t tx_exp_pos = mpb_advance(tx_pos_q, rate_select_i);
	wire mpb_pos_t tx_cur_pos = tx_pin.frame ? j0_pos : tx_exp_pos;
	wire tx_j0_ok = (tx_exp_pos == j0_pos);
	wire tx_au_byte = ~mpb_in_soh(tx_cur_pos, rate_select_i) |
		(tx_cur_pos.row == MPB_PTR_ROW);

	// Lock needs two J0 pulses a frame apart; a stray one restarts it
	always_comb begin
		tx_state_d = tx_state_q;
		case (tx_state_q)
			MPB_HUNT: begin
				if (tx_take && tx_pin.frame)
					tx_state_d = MPB_ALIGN;
			end
			MPB_ALIGN, MPB_LOCK: begin
				if (tx_take && tx_pin.frame)
					tx_state_d = tx_j0_ok ? MPB_LOCK : MPB_ALIGN;
			end
			default: tx_state_d = MPB_HUNT;
		endcase
	end

	// Byte capture and frame counter
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			tx_clk_q <= 1'b0;
			tx_pos_q <= MPB_POS_RST;
			tx_state_q <= MPB_HUNT;
			tx_byte_o <= MPB_BYTE_RST;
			tx_byte_valid_o <= 1'b0;
			tx_byte_stb_o <= 1'b0;
			tx_frame_align_o <= 1'b0;
		end else if (ce_i) begin
			tx_clk_q <= tx_clk_s;
			tx_state_q <= tx_slave_i ? tx_state_d : MPB_HUNT;
			tx_byte_stb_o <= tx_take;
			tx_frame_align_o <= tx_take & tx_pin.frame;
			if (tx_take) begin
				tx_pos_q <= tx_cur_pos;
				tx_byte_o <= tx_pin.data;
				tx_byte_valid_o <= tx_au_byte;
			end
		end
	end

	// Pin side outputs; the payload enable pin is never driven here
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			tx_prot_clk_out_o <= 1'b0;
			tx_prot_payload_en_o <= 1'b0;
			tx_prot_payload_en_oe_o <= 1'b0;
			tx_locked_o <= 1'b0;
		end else if (ce_i) begin
			tx_prot_clk_out_o <= tx_slave_i & tx_clk_s;
			tx_prot_payload_en_o <= 1'b0;
			tx_prot_payload_en_oe_o <= 1'b0;
			tx_locked_o <= (tx_state_d == MPB_LOCK) & tx_slave_i;
		end
	end

	// ----------------------------------------------------------------
	// Receive master side
	// ----------------------------------------------------------------
	logic [12:0] rx_sync;
	logic rx_clk_q;
	mpb_pos_t rx_pos_q;

	mpb_sync #(.W(13)) u_rx_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.d_i({rx_prot_clk_in_i, rx_prot_i}),
		.q_o(rx_sync)
	);

	wire rx_clk_s = rx_sync[12];
	wire mpb_rx_pin_t rx_pin = mpb_rx_pin_t'(rx_sync[11:0]);
	// Pins change on the peer's rising edge, so sample mid-byte
	// clock ignored in slave
	wire rx_take = ~rx_slave_i & rx_clk_q & ~rx_clk_s;
	wire mpb_pos_t rx_cur_pos = rx_pin.frame ? j0_pos :
		mpb_advance(rx_pos_q, rate_select_i);
	wire rx_k1_hit = rx_take & (rx_cur_pos == k1_pos);
	wire rx_k2_hit = rx_take & (rx_cur_pos == k2_pos);

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rx_clk_q <= 1'b0;
			rx_pos_q <= MPB_POS_RST;
			rx_vc_byte_o <= MPB_BYTE_RST;
			rx_vc_valid_o <= 1'b0;
			rx_frame_o <= 1'b0;
		end else if (ce_i) begin
			rx_clk_q <= rx_clk_s;
			rx_vc_valid_o <= rx_take & rx_pin.payload_en;
			rx_frame_o <= rx_take & rx_pin.frame;
			if (rx_take) begin
				rx_pos_q <= rx_cur_pos;
				rx_vc_byte_o <= rx_pin.data;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rx_k1_o <= MPB_BYTE_RST;
			rx_k2_o <= MPB_BYTE_RST;
			rx_aps_valid_o <= 1'b0;
		end else if (ce_i) begin
			rx_aps_valid_o <= rx_k2_hit;
			if (rx_k1_hit)
				rx_k1_o <= rx_pin.data;
			if (rx_k2_hit)
				rx_k2_o <= rx_pin.data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rx_sf_o <= 1'b0;
			rx_sd_o <= 1'b0;
		end else if (ce_i) begin
			rx_sf_o <= ~rx_slave_i & rx_pin.signal_fail;
			rx_sd_o <= ~rx_slave_i & rx_pin.signal_degrade;
		end
	end

	// ----------------------------------------------------------------
	// Receive byte clock and slave drive
	// ----------------------------------------------------------------
	logic [7:0] div_q;
	localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);
	wire div_end = (div_q == DIV_LAST);
	wire rx_rise = div_end & ~rx_prot_clk_out_o;
	wire rx_slave_take = rx_slave_i & rx_rise;

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			div_q <= MPB_DIV_RST;
			rx_prot_clk_out_o <= 1'b0;
		end else if (ce_i) begin
			div_q <= div_end ? MPB_DIV_RST : div_q + 8'h01;
			if (div_end)
				rx_prot_clk_out_o <= ~rx_prot_clk_out_o;
		end
	end

	// Data and markers move in the same edge as the clock rises
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rx_prot_o <= '0;
			rx_prot_oe_o <= 1'b0;
			rx_src_take_o <= 1'b0;
		end else if (ce_i) begin
			rx_prot_oe_o <= rx_slave_i;
			rx_src_take_o <= rx_slave_take;
			rx_prot_o.signal_fail <= rx_slave_i & rx_defect_i;
			rx_prot_o.signal_degrade <= rx_slave_i & rx_degrade_i;
			if (rx_slave_take) begin
				rx_prot_o.data <= rx_src_i.data;
				rx_prot_o.frame <= rx_src_i.frame;
				rx_prot_o.payload_en <= rx_src_i.payload_en;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_tx_fall;
		ce_i && tx_slave_i && tx_clk_q && !tx_clk_s;
	endsequence

	sequence s_tx_frame;
		s_tx_fall ##0 tx_pin.frame;
	endsequence

	tx_capture_a: assert property (s_tx_fall |=>
		tx_byte_stb_o && tx_byte_o == $past(tx_pin.data))
		else $error("tx byte not taken on clock fall");

	tx_au_valid_a: assert property (
		tx_byte_stb_o && tx_pos_q.row != MPB_PTR_ROW &&
		mpb_in_soh(tx_pos_q, rate_select_i) |-> !tx_byte_valid_o)
		else $error("tx overhead byte flagged valid");

	tx_frame_sync_a: assert property (s_tx_frame |=>
		tx_frame_align_o && tx_pos_q.row == 4'h0 &&
		tx_pos_q.col == (rate_select_i ? 9'h006 : 9'h002))
		else $error("tx frame not aligned on J0");

	tx_auen_off_a: assert property (tx_slave_i |->
		##1 !tx_prot_payload_en_oe_o)
		else $error("tx payload enable driven");

	tx_clk_out_a: assert property (ce_i && tx_slave_i |=>
		tx_prot_clk_out_o == $past(tx_clk_s))
		else $error("tx clock out not following input");

	rx_vc_mark_a: assert property (
		ce_i && rx_take && rx_pin.payload_en |=> rx_vc_valid_o)
		else $error("rx container byte missed");

	rx_aps_rec_a: assert property (ce_i && rx_k2_hit |=>
		rx_aps_valid_o && rx_k2_o == $past(rx_pin.data))
		else $error("rx switching byte not recovered");

	rx_clk_ign_a: assert property (rx_slave_i |->
		##1 !rx_vc_valid_o && !rx_frame_o)
		else $error("rx slave took receive clock");

	rx_drive_a: assert property (ce_i |=>
		rx_prot_oe_o == $past(rx_slave_i))
		else $error("rx bus drive wrong for role");

	rx_rise_a: assert property (ce_i && rx_slave_take |=>
		rx_prot_clk_out_o && rx_src_take_o &&
		rx_prot_o.data == $past(rx_src_i.data))
		else $error("rx data not in phase with clock");

	rx_sf_mon_a: assert property (ce_i && rx_slave_i |=>
		rx_prot_o.signal_fail == $past(rx_defect_i) &&
		rx_prot_o.signal_degrade == $past(rx_degrade_i))
		else $error("rx fail or degrade not following monitor");

endmodule : mpb_port

// ==== mpb_peer.sv ====
module mpb_peer
	import mpb_pkg::*;
(
	input wire logic en_i,
	input wire logic rate_i,
	input wire logic sf_i,
	input wire logic sd_i,
	output logic link_clk_o,
	output mpb_tx_pin_t tx_o,
	output mpb_rx_pin_t rx_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int row;
	int col;
	int cnt;
	int ncol;
	int soh;
	bit fresh;

	// ----------------------------------------------------------------
	// Protection peer: master tx bus and slave rx bus on one link clock
	// ----------------------------------------------------------------
	initial begin
		link_clk_o = 1'b0;
		tx_o = '0;
		rx_o = '0;
		cnt = 0;
		fresh = 1'b1;
		#37;
		forever begin
			ncol = rate_i ? int'(MPB_COLS_STM1) : int'(MPB_COLS_STM0);
			soh = rate_i ? int'(MPB_SOH_STM1) : int'(MPB_SOH_STM0);
			if (!en_i) begin
				// Clock stands still; stale data must not look valid
				tx_o.data = ~tx_o.data;
				rx_o.data = ~rx_o.data;
				fresh = 1'b1;
				#400;
			end else begin
				if (fresh) begin
					row = 0;
					col = rate_i ? int'(MPB_J0_COL_STM1) : int'(MPB_J0_COL_STM0);
					fresh = 1'b0;
				end
				// period equals the byte rate of the bench
				#200;
				link_clk_o = 1'b1;
				// all pins change just after the rise
				tx_o.data = cnt[7:0] ^ 8'h5a;
				tx_o.frame = (row == 0) && (col == (rate_i ? 6 : 2));
				rx_o.data = cnt[7:0] ^ 8'ha5;
				rx_o.frame = tx_o.frame;
				rx_o.payload_en = (col >= soh);
				rx_o.signal_fail = sf_i;
				rx_o.signal_degrade = sd_i;
				#200;
				link_clk_o = 1'b0;
				cnt++;
				col++;
				if (col == ncol) begin
					col = 0;
					row = (row == 8) ? 0 : row + 1;
				end
			end
		end
	end
endmodule : mpb_peer

// ==== mpb_port_tb.sv ====
module mpb_port_tb
	import mpb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic rate_select_i = 1'b0;
	logic tx_slave_i = 1'b1;
	logic rx_slave_i = 1'b0;
	logic peer_en = 1'b0;
	logic peer_sf = 1'b0;
	logic peer_sd = 1'b0;
	logic link_clk;
	mpb_tx_pin_t tx_pins;
	mpb_rx_pin_t peer_rx;
	mpb_rx_pin_t rx_pins;
	mpb_rx_pin_t rx_prot_o;
	mpb_rx_src_t rx_src_i = '0;
	logic rx_defect_i = 1'b0;
	logic rx_degrade_i = 1'b0;
	logic rx_prot_oe_o, rx_prot_clk_out_o, rx_src_take_o, tx_prot_clk_out_o;
	logic tx_prot_payload_en_o, tx_prot_payload_en_oe_o, tx_byte_valid_o;
	logic tx_byte_stb_o, tx_frame_align_o, tx_locked_o, rx_vc_valid_o;
	logic rx_frame_o, rx_aps_valid_o, rx_sf_o, rx_sd_o;
	logic [7:0] tx_byte_o, rx_vc_byte_o, rx_k1_o, rx_k2_o, ek1, ek2;
	logic [31:0] seed = 32'h8edddece;
	logic [9:0] txq[$];
	logic [8:0] rxq[$];
	logic [9:0] e;
	int r, c, nfr_exp, nfr_seen, errors, n_tests;

	// ----------------------------------------------------------------
	// Clock, pin resolution, instances
	// ----------------------------------------------------------------
	initial forever #25 clk_i = ~clk_i;
	// Shared rx pins: whoever has the enable owns them
	assign rx_pins = rx_prot_oe_o ? rx_prot_o : peer_rx;

	mpb_peer mpb_peer_i (.en_i(peer_en), .rate_i(rate_select_i),
		.sf_i(peer_sf), .sd_i(peer_sd), .link_clk_o(link_clk),
		.tx_o(tx_pins), .rx_o(peer_rx));

	mpb_port #(.HALF_DIV(4)) mpb_port_i (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .ce_i(1'b1), .rate_select_i(rate_select_i),
		.tx_slave_i(tx_slave_i), .rx_slave_i(rx_slave_i),
		.tx_prot_clk_in_i(link_clk), .tx_prot_i(tx_pins),
		.tx_prot_clk_out_o(tx_prot_clk_out_o),
		.tx_prot_payload_en_o(tx_prot_payload_en_o),
		.tx_prot_payload_en_oe_o(tx_prot_payload_en_oe_o),
		.tx_byte_o(tx_byte_o), .tx_byte_valid_o(tx_byte_valid_o),
		.tx_byte_stb_o(tx_byte_stb_o), .tx_frame_align_o(tx_frame_align_o),
		.tx_locked_o(tx_locked_o), .rx_prot_clk_in_i(link_clk),
		.rx_prot_i(rx_pins), .rx_prot_o(rx_prot_o),
		.rx_prot_oe_o(rx_prot_oe_o), .rx_prot_clk_out_o(rx_prot_clk_out_o),
		.rx_src_i(rx_src_i), .rx_defect_i(rx_defect_i),
		.rx_degrade_i(rx_degrade_i), .rx_src_take_o(rx_src_take_o),
		.rx_vc_byte_o(rx_vc_byte_o), .rx_vc_valid_o(rx_vc_valid_o),
		.rx_frame_o(rx_frame_o), .rx_k1_o(rx_k1_o), .rx_k2_o(rx_k2_o),
		.rx_aps_valid_o(rx_aps_valid_o), .rx_sf_o(rx_sf_o), .rx_sd_o(rx_sd_o));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Xorshift step; the caller keeps the state in seed
	function automatic logic [31:0] next_rnd(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		v = v ^ (v << 5);
		return v;
	endfunction : next_rnd

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	// ----------------------------------------------------------------
	// Reference model: frame position from J0, one entry per link byte
	// ----------------------------------------------------------------
	// Reset gates out the settling edge of the link clock at time zero
	always @(negedge link_clk) if (reset_n_i) begin
		if (tx_pins.frame) begin
			r = 0;
			c = rate_select_i ? 6 : 2;
		end else begin
			c++;
			if (c == (rate_select_i ? 270 : 90)) begin
				c = 0;
				r = (r == 8) ? 0 : r + 1;
			end
		end
		if (tx_slave_i)
			txq.push_back({(c >= (rate_select_i ? 9 : 3)) || (r == 3),
				tx_pins.frame, tx_pins.data});
		if (!rx_slave_i) begin
			rxq.push_back({peer_rx.payload_en, peer_rx.data});
			nfr_exp += peer_rx.frame;
			if (r == 4 && c == (rate_select_i ? 3 : 1))
				ek1 = peer_rx.data;
			if (r == 4 && c == (rate_select_i ? 6 : 2))
				ek2 = peer_rx.data;
		end
	end

	// Compare every result the design announces
	always @(posedge clk_i) if (reset_n_i) begin
		if (tx_byte_stb_o === 1'b1) begin
			e = (txq.size() > 0) ? txq.pop_front() : 10'h3ff;
			check(tx_byte_o, e[7:0]);
			check(tx_byte_valid_o, e[9]);
			check(tx_frame_align_o, e[8]);
			check(tx_prot_clk_out_o, 1'b0);
		end
		if (rx_vc_valid_o === 1'b1) begin
			while (rxq.size() > 0 && !rxq[0][8])
				void'(rxq.pop_front());
			e = (rxq.size() > 0) ? {1'b0, rxq.pop_front()} : 10'h3ff;
			check({1'b1, rx_vc_byte_o}, e[8:0]);
		end
		nfr_seen += (rx_frame_o === 1'b1);
		if (rx_aps_valid_o === 1'b1)
			check({rx_k1_o, rx_k2_o}, {ek1, ek2});
		check({tx_prot_payload_en_oe_o, tx_prot_payload_en_o}, 2'b00);
		if (rx_slave_i)
			check({rx_vc_valid_o, rx_frame_o}, 2'b00);
		if (rx_slave_i && rx_src_take_o === 1'b1) begin
			check(rx_prot_o[11:2], rx_src_i);
			check(rx_prot_o[1:0], {rx_defect_i, rx_degrade_i});
			check({rx_prot_oe_o, rx_prot_clk_out_o, rx_sf_o}, 3'b110);
			check({tx_byte_stb_o, tx_locked_o}, 2'b00);
			seed = next_rnd(seed);
			rx_src_i <= seed[9:0];
			rx_defect_i <= seed[12];
			rx_degrade_i <= seed[15];
		end
	end

	// ----------------------------------------------------------------
	// Main sequence: tx slave and rx master at both rates, then rx slave
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk_i);
		reset_n_i <= 1'b1;
		for (int rate = 0; rate < 2; rate++) begin
			@(posedge clk_i);
			rate_select_i <= rate[0];
			peer_en <= 1'b1;
			repeat (rate ? 41 : 29) begin
				seed = next_rnd(seed);
				peer_sf <= seed[3];
				peer_sd <= seed[7];
				repeat (500) @(posedge clk_i);
				check({rx_sf_o, rx_sd_o}, {peer_sf, peer_sd});
			end
			check(tx_locked_o, 1'b1);
			peer_en <= 1'b0;
			repeat (20) @(posedge clk_i);
			txq.delete();
			rxq.delete();
		end
		check(nfr_seen, nfr_exp);
		// Peer clock runs again so the ignored input really toggles
		peer_en <= 1'b1;
		tx_slave_i <= 1'b0;
		rx_slave_i <= 1'b1;
		repeat (250) @(posedge clk_i);
		check(tx_locked_o, 1'b0);
		print_verdict();
	end

	// Watchdog: the sequence needs about 35300 cycles
	initial begin
		repeat (60000) @(posedge clk_i);
		errors++;
		print_verdict();
	end
endmodule : mpb_port_tb
